// *** logic/adc_ctrl_pkg.sv ***
// package: register map, field layout, reset values and timing for the converter control block
// What this block does
// - Gain code n gives gain 2^n up to 128; input select; sleep; all reset zero.
// - Output word is 16 bits when width select is 0, 24 bits when 1; resets 0.
// - Bias compensation and open-sensor currents follow their bits; both reset off.
// - One polarity bit for both inputs: 0 bipolar, 1 unipolar; resets bipolar.
// - A 12-bit notch code sets cutoff, first notch position and output word rate.
// - First notch is master clock over 512 over the code; codes 19 to 2000 (the notch register stores any 12-bit code unchecked).
// - One new output word per notch period.
// - After an unsynchronised input step, settled within four word periods.
// - Step during held-low filter restart settles within three word periods.
// - After a channel change, settled within three word periods regardless of restart.
// - Filter -3 dB cutoff is 0.262 times the first notch frequency.
// - After reset the notch code places the first notch at 60 Hz.
`default_nettype none
package adc_ctrl_pkg;
   // timing
   localparam int SYS_CLK_HZ       = 125_000_000;
   localparam int CLKIN_DIV        = 12;          // master clock as an enable from sys_clk
   localparam int CLKIN_HZ         = SYS_CLK_HZ / CLKIN_DIV;
   localparam int DECIM            = 512;
   localparam int NOTCH_MIN        = 19;
   localparam int NOTCH_MAX        = 2000;
   localparam int DEFAULT_NOTCH_HZ = 60;
   localparam int CUTOFF_PERMILLE  = 262;
   // cutoff in mHz times the code, so the cutoff is this over the code
   localparam logic [31:0] CUTOFF_NUM = 32'(CLKIN_HZ / DECIM * CUTOFF_PERMILLE);
   localparam logic [2:0]  SETTLE_STEP    = 3'h4;
   localparam logic [2:0]  SETTLE_RESTART = 3'h3;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_NOTCH  = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_DATA   = 8'h0c;
   localparam logic [7:0] OFF_CUTOFF = 8'h10;
   // control fields
   localparam int CTRL_GAIN_LSB = 0;
   localparam int CTRL_SEL_BIT  = 3;
   localparam int CTRL_SLEEP    = 4;
   localparam int CTRL_WIDTH    = 5;
   localparam int CTRL_BIAS     = 6;
   localparam int CTRL_OPEN     = 7;
   localparam int CTRL_POL      = 8;
   localparam int CTRL_W        = 9;
   // status fields
   localparam int STAT_READY   = 0;
   localparam int STAT_SETTLED = 1;
   localparam int STAT_SLEEP   = 2;
   localparam int STAT_CNT_LSB = 4;
   // reset values
   localparam logic [CTRL_W-1:0] CTRL_RST  = 9'h000;
   localparam logic [11:0]       NOTCH_RST = 12'((CLKIN_HZ / DECIM + DEFAULT_NOTCH_HZ / 2) / DEFAULT_NOTCH_HZ);

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_WAIT = 2'b01,
      PH_DONE = 2'b10
   } bus_ph_t;

   typedef struct packed {
      logic [7:0] gain_factor;
      logic       input_select;
      logic       sleep_request;
      logic       output_width_select;
      logic       bias_comp_en;
      logic       open_sensor_current_en;
      logic       unipolar;
   } cfg_t;
endpackage
`default_nettype wire

// *** logic/adc_ctrl.sv ***
// module: converter field decode, word rate timer and settling tracker behind an AHB-Lite slave
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl
   import adc_ctrl_pkg::*;
#(
   parameter int DECIM_P   = DECIM,
   parameter int CLK_DIV_P = CLKIN_DIV
) (
   input  wire logic        sys_clk,          // 125 MHz
   input  wire logic        rst,              // async, active high
   input  wire logic        hsel,             // slave select
   input  wire logic [31:0] haddr,            // byte address
   input  wire logic [1:0]  htrans,           // transfer type
   input  wire logic        hwrite,           // write
   input  wire logic [2:0]  hsize,            // word only
   input  wire logic [31:0] hwdata,           // write data
   input  wire logic        hready,           // bus ready
   output logic      [31:0] hrdata,           // read data
   output logic             hreadyout,        // slave ready
   output logic             hresp,            // always okay
   input  wire logic        filter_restart_n, // pin, low holds filter in reset
   input  wire logic [23:0] conv_data,        // filter result from datapath
   output cfg_t             cfg,              // decoded control fields
   output logic      [23:0] out_word,         // latched output word
   output logic             word_strobe,      // one-cycle pulse per word
   output logic             data_ready_n,     // low while a word waits
   output logic             settled           // result fully settled
);
   localparam int DW = $clog2(DECIM_P);
   localparam int VW = $clog2(CLK_DIV_P + 1);

   typedef struct packed {
      bus_ph_t           ph;
      logic [7:0]        addr;
      logic              wr;
      logic [31:0]       rdata;
      logic [CTRL_W-1:0] ctrl;
      logic [11:0]       notch;
      logic [VW-1:0]     div;
      logic [DW-1:0]     decim;
      logic [11:0]       code_cnt;
      logic [2:0]        rst_sync;
      logic              held;
      logic [23:0]       word;
      logic              ready;
      logic              strobe;
      logic [2:0]        settle_cnt;
      logic [2:0]        settle_need;
   } st_t;

   st_t         s;
   st_t         n;
   logic        tick;
   logic        wr_ctrl;
   logic        wr_notch;
   logic        sel_change;
   logic        step_change;
   logic        restart;
   logic        word_evt;
   logic [31:0] cutoff_mhz;
   logic [31:0] status_word;

   always_comb begin
      cutoff_mhz = (s.notch == 12'h000) ? 32'h0 : CUTOFF_NUM / {20'h0, s.notch};
      status_word = '0;
      status_word[STAT_READY] = s.ready;
      status_word[STAT_SETTLED] = settled;
      status_word[STAT_SLEEP] = s.ctrl[CTRL_SLEEP];
      status_word[STAT_CNT_LSB +: 3] = s.settle_cnt;
      n = s;
      n.strobe = 1'b0;
      // first stage feeds only the second; a level counts once stages two and three agree
      n.rst_sync = {s.rst_sync[1:0], filter_restart_n};
      if (s.rst_sync[1] == s.rst_sync[2]) begin
         n.held = ~s.rst_sync[2];
      end
      tick = (s.div == VW'(CLK_DIV_P - 1));
      n.div = tick ? '0 : VW'(s.div + 1'b1);
      wr_ctrl = (s.ph == PH_WAIT) && s.wr && (s.addr == OFF_CTRL);
      wr_notch = (s.ph == PH_WAIT) && s.wr && (s.addr == OFF_NOTCH);
      sel_change = wr_ctrl && (hwdata[CTRL_SEL_BIT] != s.ctrl[CTRL_SEL_BIT]);
      step_change = wr_ctrl && ((hwdata[CTRL_GAIN_LSB +: 3] != s.ctrl[CTRL_GAIN_LSB +: 3]) ||
                                (hwdata[CTRL_POL] != s.ctrl[CTRL_POL]));
      // bus: one wait state so read data always leaves a flop
      unique case (s.ph)
         PH_WAIT: begin
            n.ph = PH_DONE;
            if (s.wr) begin
               if (wr_ctrl) begin
                  n.ctrl = hwdata[CTRL_W-1:0];
               end
               if (wr_notch) begin
                  n.notch = hwdata[11:0];
               end
            end else begin
               unique case (s.addr)
                  OFF_CTRL:   n.rdata = {23'h0, s.ctrl};
                  OFF_NOTCH:  n.rdata = {20'h0, s.notch};
                  OFF_STATUS: n.rdata = status_word;
                  OFF_DATA:   n.rdata = {8'h00, s.word};
                  OFF_CUTOFF: n.rdata = cutoff_mhz;
                  default:    n.rdata = 32'h0;
               endcase
               if (s.addr == OFF_DATA) begin
                  n.ready = 1'b0;
               end
            end
         end
         PH_IDLE, PH_DONE: begin
            n.ph = PH_IDLE;
            if (hsel && htrans[1] && hready) begin
               n.ph = PH_WAIT;
               n.addr = haddr[7:0];
               n.wr = hwrite;
            end
         end
         default: n.ph = PH_IDLE;
      endcase
      // a channel change, a new rate, sleep or the restart pin all reset the filter
      restart = s.held || sel_change || wr_notch || s.ctrl[CTRL_SLEEP];
      word_evt = 1'b0;
      if (restart) begin
         n.decim = '0;
         n.code_cnt = 12'h000;
         n.settle_cnt = 3'h0;
         n.settle_need = SETTLE_RESTART;
      end else begin
         if (step_change) begin
            // a step the filter did not see reset for needs the full filter length
            n.settle_cnt = 3'h0;
            n.settle_need = SETTLE_STEP;
         end
         if (tick) begin
            if (s.decim == DW'(DECIM_P - 1)) begin
               n.decim = '0;
               if (s.code_cnt >= 12'(s.notch - 12'h001)) begin
                  n.code_cnt = 12'h000;
                  word_evt = 1'b1;
               end else begin
                  n.code_cnt = 12'(s.code_cnt + 12'h001);
               end
            end else begin
               n.decim = DW'(s.decim + 1'b1);
            end
         end
      end
      if (word_evt) begin
         // set wins over a data read in the same cycle
         n.ready = 1'b1;
         n.strobe = 1'b1;
         n.word = s.ctrl[CTRL_WIDTH] ? conv_data : {8'h00, conv_data[23:8]};
         if (!step_change && s.settle_cnt < SETTLE_STEP) begin
            n.settle_cnt = 3'(s.settle_cnt + 3'h1);
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s.ph <= PH_IDLE;
         s.addr <= 8'h00;
         s.wr <= 1'b0;
         s.rdata <= 32'h0;
         s.ctrl <= CTRL_RST;
         s.notch <= NOTCH_RST;
         s.div <= '0;
         s.decim <= '0;
         s.code_cnt <= 12'h000;
         s.rst_sync <= 3'h7;
         s.held <= 1'b0;
         s.word <= 24'h0;
         s.ready <= 1'b0;
         s.strobe <= 1'b0;
         s.settle_cnt <= 3'h0;
         s.settle_need <= SETTLE_RESTART;
      end else begin
         s <= n;
      end
   end

   always_comb begin
      cfg.gain_factor = 8'h01 << s.ctrl[CTRL_GAIN_LSB +: 3];
      cfg.input_select = s.ctrl[CTRL_SEL_BIT];
      cfg.sleep_request = s.ctrl[CTRL_SLEEP];
      cfg.output_width_select = s.ctrl[CTRL_WIDTH];
      cfg.bias_comp_en = s.ctrl[CTRL_BIAS];
      cfg.open_sensor_current_en = s.ctrl[CTRL_OPEN];
      cfg.unipolar = s.ctrl[CTRL_POL];
   end

   assign hrdata = s.rdata;
   assign hreadyout = (s.ph != PH_WAIT);
   assign hresp = 1'b0;
   assign out_word = s.word;
   assign word_strobe = s.strobe;
   assign data_ready_n = ~s.ready;
   assign settled = (s.settle_cnt >= s.settle_need);

   // helper: master clock ticks since the last word or restart
   logic [31:0] gap_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gap_q <= 32'h0;
      end else if (restart || word_evt) begin
         gap_q <= 32'h0;
      end else if (tick) begin
         gap_q <= 32'(gap_q + 32'h1);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_ctrl_wr;
      (s.ph == PH_WAIT) && s.wr && (s.addr == OFF_CTRL);
   endsequence
   sequence s_notch_wr;
      (s.ph == PH_WAIT) && s.wr && (s.addr == OFF_NOTCH);
   endsequence

   property p_gain_decode;
      $onehot(cfg.gain_factor) && cfg.gain_factor[s.ctrl[CTRL_GAIN_LSB +: 3]];
   endproperty
   a_gain_decode: assert property (p_gain_decode) else $error("gain factor not 2^code");

   property p_width_16;
      word_strobe && !$past(cfg.output_width_select) |-> out_word[23:16] == 8'h00;
   endproperty
   a_width_16: assert property (p_width_16) else $error("16-bit word has upper bits set");

   property p_currents;
      s_ctrl_wr |=> cfg.bias_comp_en == $past(hwdata[CTRL_BIAS]) &&
                    cfg.open_sensor_current_en == $past(hwdata[CTRL_OPEN]);
   endproperty
   a_currents: assert property (p_currents) else $error("current enable not taken from write");

   property p_polarity;
      s_ctrl_wr |=> cfg.unipolar == $past(hwdata[CTRL_POL]);
   endproperty
   a_polarity: assert property (p_polarity) else $error("polarity not taken from write");

   property p_notch_store;
      s_notch_wr |=> s.notch == $past(hwdata[11:0]) ##1 settled == 1'b0;
   endproperty
   a_notch_store: assert property (p_notch_store) else $error("notch code not stored");

   property p_word_period;
      // counted at the event so the first word after a restart is measured like the rest
      word_evt |-> (gap_q + 32'h1) == ({20'h0, s.notch} * 32'(DECIM_P));
   endproperty
   a_word_period: assert property (p_word_period) else $error("word period not 512 x code ticks");

   property p_ready_flag;
      word_strobe |-> !data_ready_n;
   endproperty
   a_ready_flag: assert property (p_ready_flag) else $error("word without ready");

   property p_settle_step;
      (s.settle_need == SETTLE_STEP) && (s.settle_cnt == 3'h3) |-> !settled;
   endproperty
   a_settle_step: assert property (p_settle_step) else $error("settled too early after step");

   property p_settle_restart;
      s.held ##1 !s.held [*3] |-> s.settle_need == SETTLE_RESTART;
   endproperty
   a_settle_restart: assert property (p_settle_restart) else $error("restart not three words");

   property p_channel_change;
      s_ctrl_wr ##0 (hwdata[CTRL_SEL_BIT] != cfg.input_select) |=>
         s.settle_need == SETTLE_RESTART && s.settle_cnt == 3'h0 && !settled;
   endproperty
   a_channel_change: assert property (p_channel_change) else $error("channel change not restarted");

   property p_cutoff;
      (s.ph == PH_WAIT) && !s.wr && (s.addr == OFF_CUTOFF) && (s.notch != 12'h000) |=>
         hrdata == CUTOFF_NUM / {20'h0, s.notch};
   endproperty
   a_cutoff: assert property (p_cutoff) else $error("cutoff readback wrong");

   property p_reset_notch;
      $past(rst) |-> s.notch == NOTCH_RST;
   endproperty
   a_reset_notch: assert property (p_reset_notch) else $error("notch default not 60 Hz");

   sequence s_addr_phase;
      hsel && htrans[1] && hready && hreadyout;
   endsequence

   property p_hresp_okay;
      hresp == 1'b0;
   endproperty
   a_hresp_okay: assert property (p_hresp_okay) else $error("slave response not okay");

   property p_one_wait;
      (s.ph == PH_WAIT) |-> !hreadyout ##1 hreadyout;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("data phase not one wait state");

   property p_addr_take;
      s_addr_phase |=> !hreadyout;
   endproperty
   a_addr_take: assert property (p_addr_take) else $error("address phase not taken");

   property p_strobe_pulse;
      word_strobe |=> !word_strobe;
   endproperty
   a_strobe_pulse: assert property (p_strobe_pulse) else $error("word strobe longer than one cycle");

   property p_sleep_no_words;
      cfg.sleep_request |=> !word_strobe;
   endproperty
   a_sleep_no_words: assert property (p_sleep_no_words) else $error("word produced while asleep");

   property p_ready_clear;
      (s.ph == PH_WAIT) && !s.wr && (s.addr == OFF_DATA) && !word_evt |=> data_ready_n;
   endproperty
   a_ready_clear: assert property (p_ready_clear) else $error("data read did not clear ready");

   property p_ready_set;
      word_evt |=> !data_ready_n && word_strobe;
   endproperty
   a_ready_set: assert property (p_ready_set) else $error("new word without ready");

   property p_word_wide;
      word_evt && cfg.output_width_select |=> out_word == $past(conv_data);
   endproperty
   a_word_wide: assert property (p_word_wide) else $error("24-bit word not taken whole");

   property p_word_narrow;
      word_evt && !cfg.output_width_select |=> out_word == {8'h00, $past(conv_data[23:8])};
   endproperty
   a_word_narrow: assert property (p_word_narrow) else $error("16-bit word not top bits");

   property p_held_restart;
      s.held |=> s.settle_cnt == 3'h0 && s.settle_need == SETTLE_RESTART;
   endproperty
   a_held_restart: assert property (p_held_restart) else $error("held restart pin did not reset filter");

   property p_step_need;
      s_ctrl_wr ##0 (step_change && !restart) |=> s.settle_need == SETTLE_STEP && s.settle_cnt == 3'h0;
   endproperty
   a_step_need: assert property (p_step_need) else $error("step did not ask four words");

   property p_settle_sat;
      s.settle_cnt <= SETTLE_STEP;
   endproperty
   a_settle_sat: assert property (p_settle_sat) else $error("settle count beyond four");

   property p_notch_restart;
      s_notch_wr |=> s.code_cnt == 12'h000 && s.decim == '0;
   endproperty
   a_notch_restart: assert property (p_notch_restart) else $error("new rate did not restart timer");
endmodule // adc_ctrl
`default_nettype wire

// *** dv/conv_source.sv ***
// partner model: stand-in for the filter datapath, one fresh result after each output word
`timescale 1ns/100ps
`default_nettype none
module conv_source (
   input  wire logic        sys_clk,     // clock
   input  wire logic        rst,         // async reset, active high
   input  wire logic        word_strobe, // block has taken a word
   output logic      [23:0] conv_data    // filter result
);
   // the result moves on after every word, so a stale or early latch shows up as a mismatch
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         conv_data <= 24'h5a3c96;
      end else if (word_strobe) begin
         conv_data <= {conv_data[22:0], ~conv_data[23]} ^ 24'h111111;
      end
   end
endmodule // conv_source
`default_nettype wire

// *** dv/adc_ctrl_tb_top.sv ***
// testbench: register accesses, word timing, settling and field decode of the converter control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module adc_ctrl_tb_top import adc_ctrl_pkg::*; ;
   localparam int PER = 4 * 19;   // word period with the short decimation and master divide
   logic        sys_clk;
   logic        rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   wire         hready = hreadyout;
   logic        hresp;
   logic        filter_restart_n;
   logic [23:0] conv_data;
   cfg_t        cfg;
   logic [23:0] out_word;
   logic        word_strobe;
   logic        data_ready_n;
   logic        settled;
   int          num_errors = 0;
   int          total_checks = 0;
   int          cycles = 0;
   int          c;
   logic [31:0] r;
   cfg_t        e;

   adc_ctrl #(.DECIM_P(4), .CLK_DIV_P(1)) adc_ctrl_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .filter_restart_n(filter_restart_n), .conv_data(conv_data),
      .cfg(cfg), .out_word(out_word), .word_strobe(word_strobe), .data_ready_n(data_ready_n), .settled(settled));
   conv_source conv_source_i (.sys_clk(sys_clk), .rst(rst), .word_strobe(word_strobe), .conv_data(conv_data));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // a hang anywhere ends the run through the same report
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         print_verdict();
      end
   end

   // one single word transfer; entered just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge sys_clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge sys_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      bus(1'b1, a, d, dummy);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bus(1'b0, a, 32'h00000000, d);
   endtask

   // cycles from the call to the edge that samples the next word pulse
   task automatic wait_word(output int n);
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (word_strobe !== 1'b1);
   endtask

   task automatic quiet(input int n, output int k);
      k = 0;
      repeat (n) begin
         @(posedge sys_clk);
         if (word_strobe === 1'b1) k++;
      end
   endtask

   // settled must stay low until word number need, then rise
   task automatic settle_run(input int need);
      for (int k = 1; k <= need; k++) begin
         wait_word(c);
         @(posedge sys_clk);
         `CHK(settled, 1'(k == need))
      end
   endtask

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      filter_restart_n = 1'b1;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      e = '{8'h01, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      `CHK(cfg, e)
      `CHK(data_ready_n, 1'b1)
      rd(OFF_CTRL, r);
      `CHK(r, 32'h00000000)
      rd(OFF_NOTCH, r);
      `CHK(r, 32'(NOTCH_RST))
      for (int n = 0; n < 8; n++) begin
         wr(OFF_CTRL, {23'h000000, n[0], n[0], n[0], n[0], 1'b0, n[1], n[2:0]});
         e = '{8'h01 << n, n[1], 1'b0, n[0], n[0], n[0], n[0]};
         `CHK(cfg, e)
         rd(OFF_CTRL, r);
         `CHK(r[8:0], {n[0], n[0], n[0], n[0], 1'b0, n[1], n[2:0]})
      end
      wr(OFF_CTRL, 32'h00000000);
      wr(OFF_NOTCH, 32'd19);
      rd(OFF_NOTCH, r);
      `CHK(r, 32'd19)
      rd(OFF_CUTOFF, r);
      `CHK(r, CUTOFF_NUM / 32'd19)
      wait_word(c);
      `CHK(out_word, {8'h00, conv_data[23:8]})
      `CHK(data_ready_n, 1'b0)
      wait_word(c);
      `CHK(c, PER)
      @(posedge sys_clk);
      `CHK(settled, 1'b0)
      wait_word(c);
      @(posedge sys_clk);
      `CHK(settled, 1'b1)
      rd(OFF_DATA, r);
      `CHK(r, {8'h00, out_word})
      @(posedge sys_clk);
      `CHK(data_ready_n, 1'b1)
      rd(8'h14, r);
      `CHK(r, 32'h00000000)
      wr(OFF_CTRL, 32'h00000020);
      wait_word(c);
      `CHK(out_word, conv_data)
      @(posedge sys_clk);
      // gain change is an unsynchronised step: four words
      wr(OFF_CTRL, 32'h00000021);
      settle_run(4);
      @(posedge sys_clk);
      wr(OFF_CTRL, 32'h00000029);
      settle_run(3);
      filter_restart_n <= 1'b0;
      quiet(3 * PER, c);
      `CHK(c, 0)
      filter_restart_n <= 1'b1;
      settle_run(3);
      @(posedge sys_clk);
      wr(OFF_CTRL, 32'h00000039);
      `CHK(cfg.sleep_request, 1'b1)
      quiet(3 * PER, c);
      `CHK(c, 0)
      print_verdict();
   end
endmodule // adc_ctrl_tb_top
`default_nettype wire
